//--- core/rirq_consts.svh
`ifndef RIRQ_CONSTS_SVH
`define RIRQ_CONSTS_SVH

// ==========================================================
// Register addresses
`define RIRQ_ADDR_SETTINGS 8'hEA
`define RIRQ_ADDR_EVENT    8'hEB
`define RIRQ_ADDR_FS_CS    8'hEC
`define RIRQ_ADDR_QSUB     8'hED

// ==========================================================
// Settings register field positions and reset value
`define RIRQ_BIT_PULSE_SEL 0
`define RIRQ_BIT_PIN_SEL   8
`define RIRQ_BIT_ERR_EN    9
`define RIRQ_BIT_PCM_EN    10
`define RIRQ_BIT_EMP_EN    11
`define RIRQ_BIT_PAR_EN    12
`define RIRQ_BIT_FS_EN     13
`define RIRQ_BIT_CS_EN     14
`define RIRQ_BIT_Q_EN      15
`define RIRQ_SETTINGS_RST  16'h0000

// ==========================================================
// Widths
`define RIRQ_CS_BITS   48
`define RIRQ_Q_BITS    80
`define RIRQ_RD_BITS   88

`endif

//--- core/rirq_pkg.sv
package rirq_pkg;

  // Live status from the receiver core
  typedef struct packed {
    logic tx_error;
    logic pll_locked;
    logic non_pcm;
    logic emphasis;
    logic parity_err;
  } rirq_status_t;

  // Event strobes from the receiver core
  typedef struct packed {
    logic fs_update;
    logic cs_block_done;
    logic q_load;
  } rirq_strobe_t;

  // Decoded settings register
  typedef struct packed {
    logic q_subcode_irq_enable;
    logic chan_status_irq_enable;
    logic fs_result_irq_enable;
    logic parity_flag_irq_enable;
    logic emp_irq_enable;
    logic pcm_irq_enable;
    logic err_irq_enable;
    logic pin_irq_select;
    logic irq_pulse_select;
  } rirq_cfg_t;

endpackage

//--- core/rirq_cs_store.sv
`timescale 1ns/1ns
`default_nettype none

module rirq_cs_store #(
  parameter int WIDTH = 48
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] data,
  output var  logic             match
);

  logic [WIDTH-1:0] prev;
  logic             have_prev;
  logic [WIDTH-1:0] next_prev;
  logic             next_have_prev;
  logic             next_match;

  // ==========================================================
  // Compare new block with stored block
  always_comb begin
    next_prev      = prev;
    next_have_prev = have_prev;
    next_match     = 1'b0;
    if (load) begin
      next_prev      = data;
      next_have_prev = 1'b1;
      next_match     = have_prev && (data == prev);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev      <= '0;
      have_prev <= 1'b0;
      match     <= 1'b0;
    end else begin
      prev      <= next_prev;
      have_prev <= next_have_prev;
      match     <= next_match;
    end
  end

endmodule

`default_nettype wire

//--- core/rirq_readout.sv
`timescale 1ns/1ns
`default_nettype none
`include "rirq_consts.svh"

module rirq_readout
  import rirq_pkg::*;
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST_B,
  input  wire rirq_status_t             STATUS,
  input  wire rirq_strobe_t             STROBE,
  input  wire logic [2:0]               FS_RANGE_CODE,
  input  wire logic [`RIRQ_CS_BITS-1:0] CS_BITS,
  input  wire logic [`RIRQ_Q_BITS-1:0]  Q_DATA,
  input  wire logic [1:0]               Q_CRC,
  input  wire logic                     WR_REQ,
  input  wire logic [7:0]               WR_ADDR,
  input  wire logic [15:0]              WR_DATA,
  input  wire logic                     RD_REQ,
  input  wire logic [7:0]               RD_ADDR,
  input  wire logic                     RD_DONE,
  output var  logic [`RIRQ_RD_BITS-1:0] RD_DATA,
  output var  logic                     RD_VALID,
  output var  logic                     EMP_INT_PIN
);

  logic       rst_meta;
  logic       rst_n;
  rirq_cfg_t  cfg;
  rirq_cfg_t  next_cfg;
  logic [7:0] rd_addr_q;
  logic [7:0] next_rd_addr_q;
  logic [`RIRQ_RD_BITS-1:0] next_rd_data;
  logic       next_rd_valid;
  logic       fs_flag;
  logic       cs_flag;
  logic       q_flag;
  logic       next_fs_flag;
  logic       next_cs_flag;
  logic       next_q_flag;
  logic       pending;
  logic       next_pending;
  logic       next_pin;
  logic [`RIRQ_Q_BITS-1:0] q_hold;
  logic [`RIRQ_Q_BITS-1:0] next_q_hold;
  logic [1:0] crc_hold;
  logic [1:0] next_crc_hold;
  logic [3:0] live_last;
  logic [3:0] live_now;
  logic       cs_match;
  logic       ev_err;
  logic       ev_pcm;
  logic       ev_emp;
  logic       ev_par;
  logic       ev_fs;
  logic       ev_cs;
  logic       ev_q;
  logic       any_ev;
  logic       clear_rd;
  logic       error_state_bit;
  logic [7:0] event_byte;

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Settings register write
  always_comb begin
    next_cfg = cfg;
    if (WR_REQ && WR_ADDR == `RIRQ_ADDR_SETTINGS) begin
      next_cfg.irq_pulse_select       = WR_DATA[`RIRQ_BIT_PULSE_SEL];
      next_cfg.pin_irq_select         = WR_DATA[`RIRQ_BIT_PIN_SEL];
      next_cfg.err_irq_enable         = WR_DATA[`RIRQ_BIT_ERR_EN];
      next_cfg.pcm_irq_enable         = WR_DATA[`RIRQ_BIT_PCM_EN];
      next_cfg.emp_irq_enable         = WR_DATA[`RIRQ_BIT_EMP_EN];
      next_cfg.parity_flag_irq_enable = WR_DATA[`RIRQ_BIT_PAR_EN];
      next_cfg.fs_result_irq_enable   = WR_DATA[`RIRQ_BIT_FS_EN];
      next_cfg.chan_status_irq_enable = WR_DATA[`RIRQ_BIT_CS_EN];
      next_cfg.q_subcode_irq_enable   = WR_DATA[`RIRQ_BIT_Q_EN];
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= rirq_cfg_t'(9'h000);
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Channel-status block comparison
  rirq_cs_store #(
    .WIDTH (`RIRQ_CS_BITS)
  ) u_cs_store (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .load  (STROBE.cs_block_done),
    .data  (CS_BITS),
    .match (cs_match)
  );

  // ==========================================================
  // Event detection and gating
  assign error_state_bit = STATUS.tx_error | ~STATUS.pll_locked;
  assign live_now = {error_state_bit, STATUS.non_pcm, STATUS.emphasis, STATUS.parity_err};
  assign ev_err   = cfg.err_irq_enable & (live_now[3] ^ live_last[3]);
  assign ev_pcm   = cfg.pcm_irq_enable & (live_now[2] ^ live_last[2]);
  assign ev_emp   = cfg.emp_irq_enable & (live_now[1] ^ live_last[1]);
  assign ev_par   = cfg.parity_flag_irq_enable & live_now[0] & ~live_last[0];
  assign ev_fs    = cfg.fs_result_irq_enable & STROBE.fs_update;
  assign ev_cs    = cfg.chan_status_irq_enable & cs_match;
  assign ev_q     = cfg.q_subcode_irq_enable & STROBE.q_load;
  assign any_ev   = ev_err | ev_pcm | ev_emp | ev_par | ev_fs | ev_cs | ev_q;
  assign clear_rd = RD_DONE && rd_addr_q == `RIRQ_ADDR_EVENT;

  // Live state bits and event status byte
  assign event_byte = {q_flag, cs_flag, fs_flag, STATUS.parity_err,
                       STATUS.emphasis, STATUS.non_pcm, error_state_bit, 1'b0};

  // ==========================================================
  // Sticky flags, interrupt state and pin
  always_comb begin
    next_fs_flag = (fs_flag & ~clear_rd) | STROBE.fs_update;
    next_cs_flag = (cs_flag & ~clear_rd) | cs_match;
    next_q_flag  = (q_flag & ~clear_rd) | STROBE.q_load;
    next_pending = (pending & ~clear_rd) | any_ev;
    if (!cfg.pin_irq_select) begin
      next_pin = STATUS.emphasis;
    end else if (cfg.irq_pulse_select) begin
      next_pin = any_ev;
    end else begin
      next_pin = next_pending;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fs_flag     <= 1'b0;
      cs_flag     <= 1'b0;
      q_flag      <= 1'b0;
      pending     <= 1'b0;
      EMP_INT_PIN <= 1'b0;
      live_last   <= 4'h0;
    end else begin
      fs_flag     <= next_fs_flag;
      cs_flag     <= next_cs_flag;
      q_flag      <= next_q_flag;
      pending     <= next_pending;
      EMP_INT_PIN <= next_pin;
      live_last   <= live_now;
    end
  end

  // ==========================================================
  // Read data capture and Q snapshot
  always_comb begin
    next_q_hold    = STROBE.q_load ? Q_DATA : q_hold;
    next_crc_hold  = STROBE.q_load ? Q_CRC : crc_hold;
    next_rd_data   = RD_DATA;
    next_rd_valid  = 1'b0;
    next_rd_addr_q = rd_addr_q;
    if (RD_REQ) begin
      next_rd_addr_q = RD_ADDR;
      next_rd_valid  = 1'b1;
      unique case (RD_ADDR)
        `RIRQ_ADDR_EVENT: next_rd_data = {80'h0, event_byte};
        `RIRQ_ADDR_FS_CS: next_rd_data = {32'h0, CS_BITS, 1'b0, FS_RANGE_CODE, 1'b0,
                                          STATUS.non_pcm, error_state_bit, 1'b0};
        `RIRQ_ADDR_QSUB:  next_rd_data = {q_hold, 6'h00, crc_hold};
        default:          next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      q_hold    <= '0;
      crc_hold  <= 2'h0;
      RD_DATA   <= '0;
      RD_VALID  <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      q_hold    <= next_q_hold;
      crc_hold  <= next_crc_hold;
      RD_DATA   <= next_rd_data;
      RD_VALID  <= next_rd_valid;
      rd_addr_q <= next_rd_addr_q;
    end
  end

  // ==========================================================
  // Checks
  AST_PARITY_GATE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (!cfg.parity_flag_irq_enable && STATUS.parity_err && !live_last[0] && !pending
    && !(ev_err | ev_pcm | ev_emp | ev_fs | ev_cs | ev_q)) |=> !pending)
    else $error("parity event passed while disabled");
  AST_LEVEL_HOLD: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (cfg.pin_irq_select && !cfg.irq_pulse_select && pending && !clear_rd && $stable(cfg))
    |=> EMP_INT_PIN) else $error("level interrupt dropped before event read");
  AST_READ_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (clear_rd && !any_ev) |=> !pending) else $error("interrupt not cleared by event read");
  AST_CS_FLAG: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (STROBE.cs_block_done && u_cs_store.have_prev && CS_BITS == u_cs_store.prev) |-> ##2 cs_flag)
    else $error("channel-status flag missed");
  AST_EVENT_LAYOUT: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (RD_REQ && RD_ADDR == `RIRQ_ADDR_EVENT) |=> RD_VALID && RD_DATA[0] == 1'b0
    && RD_DATA[7:1] == $past(event_byte[7:1])) else $error("event register layout wrong");
  AST_FS_LAYOUT: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (RD_REQ && RD_ADDR == `RIRQ_ADDR_FS_CS) |=> RD_DATA[55:8] == $past(CS_BITS)
    && RD_DATA[6:4] == $past(FS_RANGE_CODE) && RD_DATA[87:56] == 32'h0) else $error("fs register layout wrong");
  AST_ERR_SAME: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (RD_REQ && RD_ADDR == `RIRQ_ADDR_FS_CS) |=> RD_DATA[2:1] == $past(event_byte[2:1]))
    else $error("error bits differ between registers");
  AST_PULSE_ONE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (cfg.pin_irq_select && cfg.irq_pulse_select && $stable(cfg) && !any_ev) |=> !EMP_INT_PIN)
    else $error("pulse mode pin held without event");
  AST_ANY_EVENT: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    any_ev |=> pending) else $error("enabled event did not raise interrupt");
  AST_FS_GATE: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    (!cfg.fs_result_irq_enable && STROBE.fs_update && !pending
    && !(ev_err | ev_pcm | ev_emp | ev_par | ev_cs | ev_q)) |=> !pending)
    else $error("fs event passed while disabled");

endmodule

`default_nettype wire

//--- sim/rirq_host.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Host controller model driving the settings and readout port
module rirq_host (
  input  wire logic        clk,
  output var  logic        wr_req,
  output var  logic [7:0]  wr_addr,
  output var  logic [15:0] wr_data,
  output var  logic        rd_req,
  output var  logic [7:0]  rd_addr,
  output var  logic        rd_done
);
  // Idle levels at time zero
  initial begin
    wr_req  = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
    rd_req  = 1'b0;
    rd_addr = 8'h00;
    rd_done = 1'b0;
  end

  // Settings write, released lines carry inverted values
  task automatic write_reg(input logic [15:0] d);
    @(posedge clk);
    wr_req  <= 1'b1;
    wr_addr <= 8'hEA;
    wr_data <= d;
    @(posedge clk);
    wr_req  <= 1'b0;
    wr_addr <= 8'h15;
    wr_data <= ~d;
  endtask

  // Read request, then end of shifting one cycle later
  task automatic read_reg(input logic [7:0] a);
    @(posedge clk);
    rd_req  <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_req  <= 1'b0;
    rd_addr <= ~a;
    rd_done <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "rirq_consts.svh"

module testbench;
  import rirq_pkg::*;
  logic                     CORE_CLK;
  logic                     RST_B;
  rirq_status_t             STATUS;
  rirq_strobe_t             STROBE;
  logic [2:0]               FS_RANGE_CODE;
  logic [`RIRQ_CS_BITS-1:0] CS_BITS;
  logic [`RIRQ_Q_BITS-1:0]  Q_DATA;
  logic [1:0]               Q_CRC;
  logic                     WR_REQ;
  logic [7:0]               WR_ADDR;
  logic [15:0]              WR_DATA;
  logic                     RD_REQ;
  logic [7:0]               RD_ADDR;
  logic                     RD_DONE;
  logic [`RIRQ_RD_BITS-1:0] RD_DATA;
  logic                     RD_VALID;
  logic                     EMP_INT_PIN;
  logic [87:0]              exp_q[$];
  logic [79:0]              q_save;
  logic [1:0]               crc_save;
  logic [47:0]              cs_a;
  logic [3:0]               sv;
  int                       n_fail;
  int                       checks_done;
  int                       seed;

  // ==========================================================
  // Instances
  rirq_host i_host (.clk(CORE_CLK), .wr_req(WR_REQ), .wr_addr(WR_ADDR), .wr_data(WR_DATA),
                    .rd_req(RD_REQ), .rd_addr(RD_ADDR), .rd_done(RD_DONE));
  rirq_readout i_dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .STATUS(STATUS), .STROBE(STROBE),
                      .FS_RANGE_CODE(FS_RANGE_CODE), .CS_BITS(CS_BITS), .Q_DATA(Q_DATA), .Q_CRC(Q_CRC),
                      .WR_REQ(WR_REQ), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .RD_REQ(RD_REQ),
                      .RD_ADDR(RD_ADDR), .RD_DONE(RD_DONE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
                      .EMP_INT_PIN(EMP_INT_PIN));

  // ==========================================================
  // Clock and checking helpers
  always #20 CORE_CLK = ~CORE_CLK;

  task automatic cmp(input string what, input logic [87:0] e, input logic [87:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic conclude();
    if (exp_q.size() != 0) n_fail++;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Expected event byte and fs register from live inputs
  function automatic logic [87:0] eb(input logic [2:0] f);
    return {80'h0, f, STATUS.parity_err, STATUS.emphasis, STATUS.non_pcm,
            STATUS.tx_error | ~STATUS.pll_locked, 1'b0};
  endfunction
  function automatic logic [87:0] ec();
    return {32'h0, CS_BITS, 1'b0, FS_RANGE_CODE, 1'b0, STATUS.non_pcm,
            STATUS.tx_error | ~STATUS.pll_locked, 1'b0};
  endfunction

  // Stimulus tasks
  task automatic rd(input logic [7:0] a, input logic [87:0] e);
    exp_q.push_back(e);
    i_host.read_reg(a);
  endtask
  task automatic rnd();
    logic [95:0] rv;
    rv = {$random(seed), $random(seed), $random(seed)};
    @(posedge CORE_CLK);
    STATUS        <= rv[4:0];
    FS_RANGE_CODE <= rv[7:5];
    Q_CRC         <= rv[9:8];
    Q_DATA        <= rv[87:8];
    CS_BITS       <= rv[95:48];
    @(posedge CORE_CLK);
  endtask
  task automatic ev(input logic [2:0] s, input logic [47:0] d);
    @(posedge CORE_CLK);
    STROBE  <= s;
    CS_BITS <= d;
    @(posedge CORE_CLK);
    STROBE  <= 3'b000;
  endtask
  task automatic pin_watch(output logic [3:0] v);
    v = 4'h0;
    #1;
    repeat (4) begin
      v = {v[2:0], EMP_INT_PIN};
      @(posedge CORE_CLK);
      #1;
    end
  endtask

  // Read data monitor, oldest note against each answer
  always @(posedge CORE_CLK) begin
    if (RD_VALID === 1'b1) begin
      if (exp_q.size() == 0) cmp("unexpected read", 88'h0, 88'h1);
      else cmp("read data", exp_q.pop_front(), RD_DATA);
    end
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    cmp("run time", 88'h0, 88'h1);
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    CORE_CLK = 1'b0;
    RST_B = 1'b0;
    STATUS = '0;
    STROBE = '0;
    FS_RANGE_CODE = 3'h0;
    CS_BITS = '0;
    Q_DATA = '0;
    Q_CRC = 2'h0;
    n_fail = 0;
    checks_done = 0;
    seed = 18883;
    repeat (6) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    for (int i = 0; i < 4; i++) begin
      rnd();
      rd(`RIRQ_ADDR_EVENT, eb(3'b000));
      rd(`RIRQ_ADDR_FS_CS, ec());
    end
    rnd();
    ev(3'b101, CS_BITS);
    q_save = Q_DATA;
    crc_save = Q_CRC;
    rnd();
    rd(`RIRQ_ADDR_EVENT, eb(3'b101));
    rd(`RIRQ_ADDR_QSUB, {q_save, 6'h00, crc_save});
    rd(`RIRQ_ADDR_EVENT, eb(3'b000));
    rd(8'hEE, 88'h0);
    cs_a = CS_BITS;
    ev(3'b010, cs_a);
    rd(`RIRQ_ADDR_EVENT, eb(3'b000));
    ev(3'b010, cs_a);
    rd(`RIRQ_ADDR_EVENT, eb(3'b010));
    ev(3'b010, ~cs_a);
    rd(`RIRQ_ADDR_EVENT, eb(3'b000));
    @(posedge CORE_CLK);
    STATUS <= 5'b01000;
    i_host.write_reg(16'h2100);
    ev(3'b100, cs_a);
    pin_watch(sv);
    cmp("pin held", 88'h1, {87'h0, sv[1:0] == 2'b11});
    rd(`RIRQ_ADDR_EVENT, eb(3'b001));
    @(posedge CORE_CLK);
    #1;
    cmp("pin released", 88'h0, {87'h0, EMP_INT_PIN});
    ev(3'b001, cs_a);
    pin_watch(sv);
    cmp("pin gated", 88'h1, {87'h0, sv == 4'h0});
    rd(`RIRQ_ADDR_EVENT, eb(3'b100));
    @(posedge CORE_CLK);
    STATUS.parity_err <= 1'b1;
    pin_watch(sv);
    cmp("parity gated", 88'h1, {87'h0, sv == 4'h0});
    @(posedge CORE_CLK);
    STATUS.parity_err <= 1'b0;
    i_host.write_reg(16'h3100);
    @(posedge CORE_CLK);
    STATUS.parity_err <= 1'b1;
    pin_watch(sv);
    cmp("parity raised", 88'h1, {87'h0, sv[1:0] == 2'b11});
    rd(`RIRQ_ADDR_EVENT, eb(3'b000));
    @(posedge CORE_CLK);
    #1;
    cmp("parity released", 88'h0, {87'h0, EMP_INT_PIN});
    // Level change on the non-PCM state bit as interrupt source, with error and emphasis sources enabled too
    i_host.write_reg(16'h0F00);
    @(posedge CORE_CLK);
    STATUS.non_pcm <= ~STATUS.non_pcm;
    pin_watch(sv);
    cmp("change raised", 88'h1, {87'h0, sv[1:0] == 2'b11});
    rd(`RIRQ_ADDR_EVENT, eb(3'b000));
    @(posedge CORE_CLK);
    #1;
    cmp("change released", 88'h0, {87'h0, EMP_INT_PIN});
    i_host.write_reg(16'h8101);
    ev(3'b001, cs_a);
    pin_watch(sv);
    cmp("pin pulse", 88'h1, {87'h0, sv == 4'b0100 || sv == 4'b1000});
    rd(`RIRQ_ADDR_EVENT, eb(3'b100));
    repeat (4) @(posedge CORE_CLK);
    conclude();
  end
endmodule

`default_nettype wire
